// [inc/agccl_pkg.sv]
// shared constants, field codes and carrier structs of the gain/count-limit block
package agccl_pkg;

  // register byte addresses on the register bus
  localparam logic [31:0] VOLT_GAIN_ADDR = 32'hffff0540;
  localparam logic [31:0] TEMP_GAIN_ADDR = 32'hffff0544;
  localparam logic [31:0] COUNT_LIMIT_ADDR = 32'hffff0548;
  localparam logic [31:0] COUNT_VALUE_ADDR = 32'hffff054c;
  localparam logic [31:0] MODE_ADDR = 32'hffff0500;
  localparam logic [31:0] CONFIG_ADDR = 32'hffff0504;
  localparam logic [31:0] CUR_CTRL_ADDR = 32'hffff0508;

  // values after reset
  localparam logic [15:0] COUNT_LIMIT_RST = 16'h0001;
  localparam logic [15:0] COUNT_VALUE_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'h0000;
  localparam logic [15:0] CUR_CTRL_RST = 16'h0000;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic CFG_CNT_EN_RST = 1'b0;

  // field positions
  localparam int unsigned CFG_CNT_EN_BIT = 0;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_W = 3;

  // converter mode codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_CONT = 3'h1;
  localparam logic [2:0] MODE_SINGLE = 3'h2;
  localparam logic [2:0] MODE_IDLE = 3'h3;
  localparam logic [2:0] MODE_VGAIN_CAL = 3'h5;
  localparam logic [2:0] MODE_TGAIN_CAL = 3'h6;

  // least idle time before a gain write is honoured
  localparam int unsigned IDLE_TIME_NS = 23000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned IDLE_CYCLES = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] IDLE_CYC = 8'(IDLE_CYCLES);

  // bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // gain fixed point: 1.0 sits at 2**GAIN_FRAC
  localparam int unsigned GAIN_FRAC = 15;

  // master to slave signals
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } agccl_axi_req_s;

  // slave to master signals
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } agccl_axi_rsp_s;

  // one conversion result with its strobe
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } agccl_conv_s;

endpackage : agccl_pkg

// [src/agccl_gain_scale.sv]
// scales one channel's conversion result by its gain coefficient
`timescale 1ns/1ps
`default_nettype none
module agccl_gain_scale #(
  parameter int unsigned DW = 16,
  parameter int unsigned GW = 16,
  parameter int unsigned FRAC = agccl_pkg::GAIN_FRAC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [DW-1:0] in_data,
  input wire logic [GW-1:0] gain,
  output logic out_valid_q,
  output logic [DW-1:0] out_data_q
);

  // full product, never truncated before the range check
  logic [DW+GW-1:0] prod;
  // bits above the kept window flag an overflow
  logic ovf;
  logic out_valid_d;
  logic [DW-1:0] out_data_d;

  // product and saturation; saturating beats wrapping for a sensor reading
  always_comb begin
    prod = {{GW{1'b0}}, in_data} * {{DW{1'b0}}, gain};
    ovf = |prod[DW+GW-1:DW+FRAC];
    out_valid_d = in_valid;
    out_data_d = out_data_q;
    if (in_valid) begin
      out_data_d = ovf ? {DW{1'b1}} : prod[DW+FRAC-1:FRAC];
    end
  end

  // result register, one cycle behind the input
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
    end
  end

endmodule : agccl_gain_scale
`default_nettype wire

// [src/agccl_top.sv]
// gain calibration registers and result-count limit behind an axi4-lite slave
//
// What this block does
// R1: keep 16-bit voltage gain, scale voltage results
// R2: load factory gain defaults at power-on
// R3: voltage gain calibration overwrites voltage gain
// R4: keep 16-bit temperature gain, scale temperature results
// R5: temperature gain calibration overwrites temperature gain
// R6: software writes gains only after 23 us idle
// R7: 16-bit limit of conversions per interrupt
// R8: limit resets to one
// R9: counting acts only while count enable set
// R10: count equal to limit clears and continues
// R11: mode or current control write clears count
// R12: count enable is config bit zero
// R13: ignore gain writes until idle time elapsed
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module agccl_top (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire agccl_pkg::agccl_axi_req_s axi_req,
  output agccl_pkg::agccl_axi_rsp_s axi_rsp,
  input wire logic [15:0] fuse_volt_gain,
  input wire logic [15:0] fuse_temp_gain,
  input wire agccl_pkg::agccl_conv_s volt_conv,
  input wire agccl_pkg::agccl_conv_s temp_conv,
  output agccl_pkg::agccl_conv_s volt_scaled,
  output agccl_pkg::agccl_conv_s temp_scaled,
  input wire logic cur_conv_done,
  input wire logic cal_volt_done,
  input wire logic [15:0] cal_volt_value,
  input wire logic cal_temp_done,
  input wire logic [15:0] cal_temp_value,
  output logic [2:0] conv_mode_q,
  output logic [15:0] cur_ctrl_q,
  output logic irq_allow_q
);

  // bus slave state
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [31:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  // handshakes and the write commit strobe
  logic aw_take, w_take, ar_take, do_write;
  // write decode
  logic wr_vgain, wr_tgain, wr_limit, wr_mode, wr_cfg, wr_cctl, wr_hit;

  // block registers
  logic [15:0] volt_gain_q, volt_gain_d;
  logic [15:0] temp_gain_q, temp_gain_d;
  logic [15:0] count_limit_q, count_limit_d;
  logic [15:0] count_value_q, count_value_d;
  logic cnt_en_q, cnt_en_d;
  logic [2:0] conv_mode_d;
  logic [15:0] cur_ctrl_d;
  logic irq_allow_d;
  // low after reset until factory gains are loaded
  logic loaded_q, loaded_d;
  // idle time counter, saturates at the threshold
  logic [7:0] idle_cnt_q, idle_cnt_d;
  logic gain_wr_ok;
  logic [15:0] count_next;

  // byte-lane merge of a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res[7:0] = strb[0] ? data[7:0] : old[7:0];
    res[15:8] = strb[1] ? data[15:8] : old[15:8];
    return res;
  endfunction : merge16

  assign aw_take = axi_req.awvalid & awready_q;
  assign w_take = axi_req.wvalid & wready_q;
  assign ar_take = axi_req.arvalid & arready_q;
  assign do_write = aw_have_q & w_have_q & ~bvalid_q;

  // address decode of the held write
  always_comb begin
    wr_vgain = do_write & (waddr_q == agccl_pkg::VOLT_GAIN_ADDR);
    wr_tgain = do_write & (waddr_q == agccl_pkg::TEMP_GAIN_ADDR);
    wr_limit = do_write & (waddr_q == agccl_pkg::COUNT_LIMIT_ADDR);
    wr_mode = do_write & (waddr_q == agccl_pkg::MODE_ADDR);
    wr_cfg = do_write & (waddr_q == agccl_pkg::CONFIG_ADDR);
    wr_cctl = do_write & (waddr_q == agccl_pkg::CUR_CTRL_ADDR);
    // count value is read only but mapped, so a write to it is accepted and dropped
    wr_hit = wr_vgain | wr_tgain | wr_limit | wr_mode | wr_cfg | wr_cctl |
             (waddr_q == agccl_pkg::COUNT_VALUE_ADDR);
  end

  // write channel: address and data taken in either order, answer after both
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (aw_take) begin
      aw_have_d = 1'b1;
      waddr_d = axi_req.awaddr;
    end
    if (w_take) begin
      w_have_d = 1'b1;
      wdata_d = axi_req.wdata;
      wstrb_d = axi_req.wstrb;
    end
    if (do_write) begin
      // unmapped addresses get a slave error
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? agccl_pkg::RESP_OKAY : agccl_pkg::RESP_SLVERR;
    end else if (bvalid_q & axi_req.bready) begin
      bvalid_d = 1'b0;
    end
    // one write at a time: no new address or data while one is open
    awready_d = ~aw_have_d & ~bvalid_d;
    wready_d = ~w_have_d & ~bvalid_d;
  end

  // read channel: data one cycle after the address is taken
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d = agccl_pkg::RESP_OKAY;
      case (axi_req.araddr)
        agccl_pkg::VOLT_GAIN_ADDR: rdata_d = {16'h0000, volt_gain_q};
        agccl_pkg::TEMP_GAIN_ADDR: rdata_d = {16'h0000, temp_gain_q};
        agccl_pkg::COUNT_LIMIT_ADDR: rdata_d = {16'h0000, count_limit_q};
        agccl_pkg::COUNT_VALUE_ADDR: rdata_d = {16'h0000, count_value_q};
        agccl_pkg::MODE_ADDR: rdata_d = {29'h00000000, conv_mode_q};
        agccl_pkg::CONFIG_ADDR: rdata_d = {31'h00000000, cnt_en_q};
        agccl_pkg::CUR_CTRL_ADDR: rdata_d = {16'h0000, cur_ctrl_q};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = agccl_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q & axi_req.rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = ~rvalid_d;
  end

  // bus slave registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= agccl_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= agccl_pkg::RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // responses straight from their flops
  always_comb begin
    axi_rsp.awready = awready_q;
    axi_rsp.wready = wready_q;
    axi_rsp.bvalid = bvalid_q;
    axi_rsp.bresp = bresp_q;
    axi_rsp.arready = arready_q;
    axi_rsp.rvalid = rvalid_q;
    axi_rsp.rdata = rdata_q;
    axi_rsp.rresp = rresp_q;
  end

  // idle timer: converter must sit in idle for the full interval
  always_comb begin
    idle_cnt_d = idle_cnt_q;
    if (conv_mode_q != agccl_pkg::MODE_IDLE) begin
      idle_cnt_d = 8'h00;
    end else if (idle_cnt_q != agccl_pkg::IDLE_CYC) begin
      idle_cnt_d = idle_cnt_q + 8'h01;
    end
    gain_wr_ok = (idle_cnt_q == agccl_pkg::IDLE_CYC); // R6
  end

  // gain, mode, config and control register next values
  always_comb begin
    loaded_d = 1'b1;
    volt_gain_d = volt_gain_q;
    temp_gain_d = temp_gain_q;
    count_limit_d = count_limit_q;
    cnt_en_d = cnt_en_q;
    conv_mode_d = conv_mode_q;
    cur_ctrl_d = cur_ctrl_q;
    if (!loaded_q) begin
      // first cycle after release takes the factory trims
      volt_gain_d = fuse_volt_gain; // R2
      temp_gain_d = fuse_temp_gain; // R2
    end else begin
      // early gain writes are silently dropped, still answered okay
      if (wr_vgain & gain_wr_ok) begin
        volt_gain_d = merge16(volt_gain_q, wdata_q, wstrb_q); // R13
      end
      if (wr_tgain & gain_wr_ok) begin
        temp_gain_d = merge16(temp_gain_q, wdata_q, wstrb_q); // R13
      end
      // a finished calibration wins over a software write in the same cycle
      if (cal_volt_done) begin
        volt_gain_d = cal_volt_value; // R3
      end
      if (cal_temp_done) begin
        temp_gain_d = cal_temp_value; // R5
      end
    end
    if (wr_limit) begin
      count_limit_d = merge16(count_limit_q, wdata_q, wstrb_q); // R7
    end
    if (wr_cfg & wstrb_q[0]) begin
      cnt_en_d = wdata_q[agccl_pkg::CFG_CNT_EN_BIT]; // R12
    end
    if (wr_cctl) begin
      cur_ctrl_d = merge16(cur_ctrl_q, wdata_q, wstrb_q);
    end
    // calibration end returns the converter to idle
    if ((cal_volt_done & (conv_mode_q == agccl_pkg::MODE_VGAIN_CAL)) |
        (cal_temp_done & (conv_mode_q == agccl_pkg::MODE_TGAIN_CAL))) begin
      conv_mode_d = agccl_pkg::MODE_IDLE;
    end
    if (wr_mode & wstrb_q[0]) begin
      conv_mode_d = wdata_q[agccl_pkg::MODE_LSB +: agccl_pkg::MODE_W];
    end
  end

  // result counter: reconfiguring the converter restarts the count
  always_comb begin
    count_next = count_value_q + 16'h0001;
    count_value_d = count_value_q;
    irq_allow_d = 1'b0;
    if (wr_mode | wr_cctl) begin
      count_value_d = agccl_pkg::COUNT_VALUE_RST; // R11
    end else if (cur_conv_done) begin
      if (!cnt_en_q) begin
        // counting off: every conversion may interrupt, except one that meets a mode or current control write
        irq_allow_d = 1'b1; // R9
      end else if (count_next == count_limit_q) begin
        count_value_d = 16'h0000; // R10
        irq_allow_d = 1'b1; // R7
      end else begin
        count_value_d = count_next;
      end
    end
  end

  // block registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      loaded_q <= 1'b0;
      volt_gain_q <= agccl_pkg::GAIN_RST;
      temp_gain_q <= agccl_pkg::GAIN_RST;
      count_limit_q <= agccl_pkg::COUNT_LIMIT_RST; // R8
      count_value_q <= agccl_pkg::COUNT_VALUE_RST;
      cnt_en_q <= agccl_pkg::CFG_CNT_EN_RST;
      conv_mode_q <= agccl_pkg::MODE_RST;
      cur_ctrl_q <= agccl_pkg::CUR_CTRL_RST;
      irq_allow_q <= 1'b0;
      idle_cnt_q <= 8'h00;
    end else begin
      loaded_q <= loaded_d;
      volt_gain_q <= volt_gain_d;
      temp_gain_q <= temp_gain_d;
      count_limit_q <= count_limit_d;
      count_value_q <= count_value_d;
      cnt_en_q <= cnt_en_d;
      conv_mode_q <= conv_mode_d;
      cur_ctrl_q <= cur_ctrl_d;
      irq_allow_q <= irq_allow_d;
      idle_cnt_q <= idle_cnt_d;
    end
  end

  // voltage channel scaling
  agccl_gain_scale #(
    .DW(16),
    .GW(16),
    .FRAC(agccl_pkg::GAIN_FRAC)
  ) u_volt_scale (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(volt_conv.valid),
    .in_data(volt_conv.data),
    .gain(volt_gain_q), // R1
    .out_valid_q(volt_scaled.valid),
    .out_data_q(volt_scaled.data)
  );

  // temperature channel scaling
  agccl_gain_scale #(
    .DW(16),
    .GW(16),
    .FRAC(agccl_pkg::GAIN_FRAC)
  ) u_temp_scale (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(temp_conv.valid),
    .in_data(temp_conv.data),
    .gain(temp_gain_q), // R4
    .out_valid_q(temp_scaled.valid),
    .out_data_q(temp_scaled.data)
  );

endmodule : agccl_top
`default_nettype wire

// [tb/agccl_top_sva.sv]
// concurrent checks on the ports of the gain/count-limit block
`timescale 1ns/1ps
`default_nettype none
module agccl_top_sva (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire agccl_pkg::agccl_axi_req_s axi_req,
  input wire agccl_pkg::agccl_axi_rsp_s axi_rsp,
  input wire agccl_pkg::agccl_conv_s volt_conv,
  input wire agccl_pkg::agccl_conv_s temp_conv,
  input wire agccl_pkg::agccl_conv_s volt_scaled,
  input wire agccl_pkg::agccl_conv_s temp_scaled,
  input wire logic cur_conv_done,
  input wire logic cal_volt_done,
  input wire logic cal_temp_done,
  input wire logic [2:0] conv_mode_q,
  input wire logic irq_allow_q
);
  // one clock domain, so one default clock and reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // both write halves taken at one edge
  sequence s_wr_take;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  // read address taken
  sequence s_rd_take;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  a_write_answer: assert property (s_wr_take |-> ##2 axi_rsp.bvalid)
    else $error("write response not on time");
  a_read_answer: assert property (s_rd_take |=> axi_rsp.rvalid)
    else $error("read data not on time");
  a_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped early");
  a_volt_scale: assert property (volt_conv.valid |=> volt_scaled.valid)
    else $error("voltage result not scaled");
  a_volt_quiet: assert property (!volt_conv.valid |=> !volt_scaled.valid)
    else $error("voltage result without input");
  a_temp_scale: assert property (temp_conv.valid |=> temp_scaled.valid)
    else $error("temperature result not scaled");
  a_irq_cause: assert property (irq_allow_q |-> $past(cur_conv_done))
    else $error("count pulse without conversion");
  a_vcal_idle: assert property (cal_volt_done && conv_mode_q == agccl_pkg::MODE_VGAIN_CAL
    |=> conv_mode_q == agccl_pkg::MODE_IDLE)
    else $error("voltage calibration did not end");
  a_tcal_idle: assert property (cal_temp_done && conv_mode_q == agccl_pkg::MODE_TGAIN_CAL
    |=> conv_mode_q == agccl_pkg::MODE_IDLE)
    else $error("temperature calibration did not end");
endmodule : agccl_top_sva
bind agccl_top agccl_top_sva agccl_top_sva_inst (.core_clk(core_clk), .arst_n(arst_n), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .volt_conv(volt_conv), .temp_conv(temp_conv), .volt_scaled(volt_scaled),
  .temp_scaled(temp_scaled), .cur_conv_done(cur_conv_done), .cal_volt_done(cal_volt_done),
  .cal_temp_done(cal_temp_done), .conv_mode_q(conv_mode_q), .irq_allow_q(irq_allow_q));
`default_nettype wire

// [tb/tb.sv]
// self-checking bench of the gain/count-limit block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0; // 10 mhz core clock
  logic arst_n = 1'b0; // held low at start
  agccl_pkg::agccl_axi_req_s req = '0; // master side
  agccl_pkg::agccl_axi_rsp_s rsp;
  logic [15:0] fv = '0; // voltage trim
  logic [15:0] ft = '0; // temperature trim
  agccl_pkg::agccl_conv_s vc = '0;
  agccl_pkg::agccl_conv_s tc = '0;
  agccl_pkg::agccl_conv_s vs;
  agccl_pkg::agccl_conv_s ts;
  logic cdone = 1'b0; // current conversion pulse
  logic cvd = 1'b0;
  logic [15:0] cvv = '0;
  logic ctd = 1'b0;
  logic [15:0] ctv = '0;
  logic [2:0] mode;
  logic [15:0] cctl;
  logic irq;
  logic cd_q = 1'b0; // conversion seen last edge
  logic [15:0] gv; // model of voltage gain
  logic [15:0] gt; // model of temperature gain
  logic [31:0] seed = 32'h00005095; // xorshift state
  logic [33:0] rq[$]; // expected resp and read data
  logic [1:0] bq[$]; // expected write resp
  logic [15:0] vq[$];
  logic [15:0] tq[$];
  logic iq[$]; // expected count pulses
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  agccl_top agccl_top_inst (.core_clk(core_clk), .arst_n(arst_n), .axi_req(req), .axi_rsp(rsp),
    .fuse_volt_gain(fv), .fuse_temp_gain(ft), .volt_conv(vc), .temp_conv(tc), .volt_scaled(vs),
    .temp_scaled(ts), .cur_conv_done(cdone), .cal_volt_done(cvd), .cal_volt_value(cvv),
    .cal_temp_done(ctd), .cal_temp_value(ctv), .conv_mode_q(mode), .cur_ctrl_q(cctl), .irq_allow_q(irq));
  // free running clock
  initial forever #50 core_clk = ~core_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // unsigned product, saturated at full scale
  function automatic logic [15:0] scl(logic [15:0] d, logic [15:0] g);
    logic [31:0] p;
    p = (32'(d) * 32'(g)) >> 15;
    return (p > 32'h0000ffff) ? 16'hffff : p[15:0];
  endfunction : scl
  task automatic chk(logic [33:0] got, logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    // results still owed by the design count against it
    chk(34'(rq.size() + bq.size() + vq.size() + tq.size() + iq.size()), 34'h0);
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  // write: both halves offered together, each dropped when taken
  task automatic wr(logic [31:0] a, logic [31:0] d, logic [1:0] r);
    bq.push_back(r);
    @(posedge core_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
  endtask : wr
  // read with rready held until the data edge
  task automatic rd(logic [31:0] a, logic [31:0] d, logic [1:0] r);
    rq.push_back({r, d});
    @(posedge core_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
  endtask : rd
  // back to back raw results on both channels
  task automatic sc(int n);
    logic [15:0] d;
    repeat (n) begin
      @(posedge core_clk);
      d = 16'(rnd());
      vc <= {1'b1, d};
      tc <= {1'b1, ~d};
      vq.push_back(scl(d, gv));
      tq.push_back(scl(~d, gt));
    end
    @(posedge core_clk);
    vc.valid <= 1'b0;
    tc.valid <= 1'b0;
  endtask : sc
  // back to back conversions, pat gives expected pulses
  task automatic cnt(logic [7:0] pat, int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      cdone <= 1'b1;
      iq.push_back(pat[i]);
    end
    @(posedge core_clk);
    cdone <= 1'b0;
  endtask : cnt
  // one-cycle calibration pulse on one channel
  task automatic cal(bit t, logic [15:0] v);
    @(posedge core_clk);
    if (t) {ctd, ctv} <= {1'b1, v};
    else {cvd, cvv} <= {1'b1, v};
    @(posedge core_clk);
    ctd <= 1'b0;
    cvd <= 1'b0;
  endtask : cal
  // result watcher, also the hang guard
  always @(posedge core_clk) begin
    if (rsp.bvalid && req.bready) chk(34'(rsp.bresp), 34'(bq.pop_front()));
    if (rsp.rvalid && req.rready) chk({rsp.rresp, rsp.rdata}, rq.pop_front());
    if (vs.valid) chk(34'(vs.data), 34'(vq.pop_front()));
    if (ts.valid) chk(34'(ts.data), 34'(tq.pop_front()));
    if (cd_q) chk(34'(irq), 34'(iq.pop_front()));
    cd_q <= cdone;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    fv = 16'(rnd());
    ft = 16'(rnd());
    gv = fv;
    gt = ft;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(agccl_pkg::COUNT_LIMIT_ADDR, 32'h00000001, agccl_pkg::RESP_OKAY);
    rd(agccl_pkg::VOLT_GAIN_ADDR, 32'(fv), agccl_pkg::RESP_OKAY);
    rd(agccl_pkg::TEMP_GAIN_ADDR, 32'(ft), agccl_pkg::RESP_OKAY);
    sc(4);
    $display("test reset and trims done");
    wr(agccl_pkg::MODE_ADDR, 32'(agccl_pkg::MODE_IDLE), agccl_pkg::RESP_OKAY);
    @(negedge core_clk) chk(34'(mode), 34'(agccl_pkg::MODE_IDLE));
    wr(agccl_pkg::VOLT_GAIN_ADDR, 32'h00008000, agccl_pkg::RESP_OKAY);
    rd(agccl_pkg::VOLT_GAIN_ADDR, 32'(fv), agccl_pkg::RESP_OKAY);
    repeat (240) @(posedge core_clk);
    wr(agccl_pkg::VOLT_GAIN_ADDR, 32'hffff8000, agccl_pkg::RESP_OKAY);
    wr(agccl_pkg::TEMP_GAIN_ADDR, 32'h0000ffff, agccl_pkg::RESP_OKAY);
    gv = 16'h8000;
    gt = 16'hffff;
    rd(agccl_pkg::VOLT_GAIN_ADDR, 32'h00008000, agccl_pkg::RESP_OKAY);
    rd(agccl_pkg::TEMP_GAIN_ADDR, 32'h0000ffff, agccl_pkg::RESP_OKAY);
    sc(6);
    $display("test idle gate and scaling done");
    wr(agccl_pkg::MODE_ADDR, 32'(agccl_pkg::MODE_VGAIN_CAL), agccl_pkg::RESP_OKAY);
    cal(1'b0, 16'h1357);
    @(negedge core_clk) chk(34'(mode), 34'(agccl_pkg::MODE_IDLE));
    gv = 16'h1357;
    wr(agccl_pkg::MODE_ADDR, 32'(agccl_pkg::MODE_TGAIN_CAL), agccl_pkg::RESP_OKAY);
    cal(1'b1, 16'h9bdf);
    @(negedge core_clk) chk(34'(mode), 34'(agccl_pkg::MODE_IDLE));
    gt = 16'h9bdf;
    rd(agccl_pkg::VOLT_GAIN_ADDR, 32'h00001357, agccl_pkg::RESP_OKAY);
    rd(agccl_pkg::TEMP_GAIN_ADDR, 32'h00009bdf, agccl_pkg::RESP_OKAY);
    sc(2);
    $display("test calibration done");
    cnt(8'h07, 3);
    wr(agccl_pkg::COUNT_LIMIT_ADDR, 32'h00000003, agccl_pkg::RESP_OKAY);
    wr(agccl_pkg::CONFIG_ADDR, 32'h00000001, agccl_pkg::RESP_OKAY);
    cnt(8'h04, 4);
    rd(agccl_pkg::COUNT_VALUE_ADDR, 32'h00000001, agccl_pkg::RESP_OKAY);
    wr(agccl_pkg::CUR_CTRL_ADDR, 32'h00001234, agccl_pkg::RESP_OKAY);
    @(negedge core_clk) chk(34'(cctl), 34'h1234);
    rd(agccl_pkg::COUNT_VALUE_ADDR, 32'h00000000, agccl_pkg::RESP_OKAY);
    rd(agccl_pkg::CUR_CTRL_ADDR, 32'h00001234, agccl_pkg::RESP_OKAY);
    cnt(8'h04, 3);
    $display("test result counting done");
    wr(32'hffff0600, 32'h0000abcd, agccl_pkg::RESP_SLVERR);
    rd(32'hffff0600, 32'h00000000, agccl_pkg::RESP_SLVERR);
    wr(agccl_pkg::COUNT_VALUE_ADDR, 32'h00000005, agccl_pkg::RESP_OKAY);
    rd(agccl_pkg::COUNT_VALUE_ADDR, 32'h00000000, agccl_pkg::RESP_OKAY);
    $display("test unmapped and read-only done");
    repeat (4) @(posedge core_clk);
    stop_test();
  end
endmodule : tb
`default_nettype wire
